// ==== inc/rtc_pkg.sv ====
// Shared constants, types and register map of the real-time trace capture block
package rtc_pkg;

   // ==========================================================================
   // Buffer geometry
   localparam int unsigned DEPTH     = 4095;
   localparam logic [11:0] CAP       = 12'hfff;
   localparam logic [11:0] LAST_IDX  = 12'hffe;
   localparam int unsigned NUM_EV    = 4;

   // ==========================================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_LENGTH  = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_RD_FROM = 8'h0c;
   localparam logic [7:0] OFS_RD_TO   = 8'h10;
   localparam logic [7:0] OFS_RD_DATA = 8'h14;
   localparam logic [7:0] OFS_EV_BASE = 8'h20;

   // ==========================================================================
   // Field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_AUTO_BIT  = 3;
   localparam int unsigned CTRL_MULTI_BIT = 4;
   localparam int unsigned CTRL_FRZ_BIT   = 5;
   localparam int unsigned LEN_MAX_BIT    = 16;
   localparam int unsigned ST_FULL_BIT    = 16;
   localparam int unsigned ST_STORE_BIT   = 17;
   localparam int unsigned ST_ARMED_BIT   = 18;
   localparam int unsigned ST_RDEND_BIT   = 19;
   localparam int unsigned EV_EN_BIT      = 16;
   localparam int unsigned EV_ROLE_BIT    = 17;

   // ==========================================================================
   // Mode codes as written by software
   localparam logic [2:0] CODE_BEG_MON = 3'h0;
   localparam logic [2:0] CODE_END_MON = 3'h1;
   localparam logic [2:0] CODE_BEG_EV  = 3'h2;
   localparam logic [2:0] CODE_END_EV  = 3'h3;
   localparam logic [2:0] CODE_CTR_EV  = 3'h4;

   // ==========================================================================
   // Reset values
   localparam logic [2:0]  RST_MODE   = CODE_END_MON;
   localparam logic        RST_AUTO   = 1'b0;
   localparam logic        RST_MULTI  = 1'b0;
   localparam logic        RST_FRZ    = 1'b0;
   localparam logic [12:0] RST_LEN    = 13'h0000;
   localparam logic        RST_LENMAX = 1'b1;
   localparam logic [11:0] RST_RD_IDX = 12'h001;

   // ==========================================================================
   // Types
   typedef enum logic [4:0] {
      MODE_BEG_MON = 5'b00001,
      MODE_END_MON = 5'b00010,
      MODE_BEG_EV  = 5'b00100,
      MODE_END_EV  = 5'b01000,
      MODE_CTR_EV  = 5'b10000
   } rtc_mode_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ARMED = 5'b00010,
      ST_STORE = 5'b00100,
      ST_POST  = 5'b01000,
      ST_DONE  = 5'b10000
   } rtc_state_t;

   // One trace entry: data, address, status
   typedef struct packed {
      logic [7:0]  data;
      logic [15:0] addr;
      logic [7:0]  status;
   } rtc_entry_t;

   // One event point
   typedef struct packed {
      logic        role_end;
      logic        en;
      logic [15:0] addr;
   } rtc_ev_t;

endpackage

// ==== rtl/rtc_match.sv ====
// One event point comparator, split by trace role
`timescale 1ns/1ps
module rtc_match (
   input  wire rtc_pkg::rtc_ev_t cfg,       // Event point setting
   input  wire logic             allow,     // Point may respond
   input  wire logic             bus_done,  // Bus cycle completes
   input  wire logic [15:0]      bus_addr,  // Address of that cycle
   output logic                  hit_start, // Start trigger hit
   output logic                  hit_end    // End trigger hit
);

   logic hit;

   assign hit       = allow && cfg.en && bus_done && (cfg.addr == bus_addr);
   assign hit_start = hit && !cfg.role_end;
   assign hit_end   = hit && cfg.role_end;

endmodule

// ==== rtl/rtc_mem.sv ====
// Trace storage: flip-flop array with one write port and one read port
`timescale 1ns/1ps
module rtc_mem (
   input  wire logic                clk,    // System clock
   input  wire logic                we,     // Write strobe
   input  wire logic [11:0]         waddr,  // Write index
   input  wire rtc_pkg::rtc_entry_t wdata,  // Entry to store
   input  wire logic [11:0]         raddr,  // Read index
   output rtc_pkg::rtc_entry_t      rdata   // Entry at read index
);

   rtc_pkg::rtc_entry_t mem [rtc_pkg::DEPTH];

   // Content needs no reset; validity is tracked by the stored count
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_comb begin
      if (raddr <= rtc_pkg::LAST_IDX) begin
         rdata = mem[raddr];
      end else begin
         rdata = '0;
      end
   end

endmodule

// ==== rtl/rtc_top.sv ====
// Real-time trace capture controller with APB register access
`timescale 1ns/1ps
module rtc_top (
   input  wire logic                clk,           // System clock, 100 MHz
   input  wire logic                rstn,          // Asynchronous reset
   input  wire logic                psel,          // APB select
   input  wire logic                penable,       // APB enable
   input  wire logic                pwrite,        // APB direction
   input  wire logic [7:0]          paddr,         // APB byte address
   input  wire logic [31:0]         pwdata,        // APB write data
   output logic [31:0]              prdata,        // APB read data
   output logic                     pready,        // APB ready
   output logic                     pslverr,       // APB error
   input  wire logic                bus_done,      // Target bus cycle completes
   input  wire rtc_pkg::rtc_entry_t bus_cycle,     // Data, address, status
   input  wire logic                run_req,       // Emulation starts, pulse
   input  wire logic                stop_req,      // Breakpoint or stop, pulse
   output logic                     trace_storing, // Storage in progress
   output logic                     trace_full     // Buffer holds capacity
);

   // ==========================================================================
   // Registers
   logic [2:0]              mode_code;
   logic                    auto_start;
   logic                    multi;
   logic                    freeze;
   logic [12:0]             len_val;
   logic                    len_max;
   logic [11:0]             rd_from;
   logic [11:0]             rd_to;
   logic [11:0]             rd_cur;
   logic                    rd_end;
   rtc_pkg::rtc_ev_t        ev_cfg [rtc_pkg::NUM_EV];

   // ==========================================================================
   // Trace state
   rtc_pkg::rtc_state_t     state;
   rtc_pkg::rtc_state_t     next_state;
   rtc_pkg::rtc_mode_t      mode;
   logic [11:0]             wptr;
   logic [11:0]             count;
   logic [11:0]             seg_cnt;
   logic [11:0]             eff_len;
   logic                    do_store;
   logic                    seg_clr;
   logic                    start_hit;
   logic                    end_hit;
   logic [rtc_pkg::NUM_EV-1:0] hs;
   logic [rtc_pkg::NUM_EV-1:0] he;
   logic [11:0]             rd_idx;
   logic [12:0]             rd_sum;
   rtc_pkg::rtc_entry_t     rd_entry;

   // APB strobes
   logic                    setup;
   logic                    acc_wr;
   logic                    acc_rd;
   logic                    ev_sel;
   logic [1:0]              ev_num;
   logic                    mapped;

   // ==========================================================================
   // Mode decode and effective length
   always_comb begin
      unique case (mode_code)
         rtc_pkg::CODE_BEG_MON: mode = rtc_pkg::MODE_BEG_MON;
         rtc_pkg::CODE_BEG_EV:  mode = rtc_pkg::MODE_BEG_EV;
         rtc_pkg::CODE_END_EV:  mode = rtc_pkg::MODE_END_EV;
         rtc_pkg::CODE_CTR_EV:  mode = rtc_pkg::MODE_CTR_EV;
         default:               mode = rtc_pkg::MODE_END_MON;
      endcase
   end

   always_comb begin
      if (len_max) begin
         eff_len = rtc_pkg::CAP;
      end else if (len_val == 13'h0000) begin
         eff_len = 12'h001;
      end else if (len_val > {1'b0, rtc_pkg::CAP}) begin
         eff_len = rtc_pkg::CAP;
      end else begin
         eff_len = len_val[11:0];
      end
   end

   // ==========================================================================
   // Event points
   genvar gi;
   generate
      for (gi = 0; gi < rtc_pkg::NUM_EV; gi++) begin : g_ev
         rtc_match u_match (
            .cfg       (ev_cfg[gi]),
            .allow     ((gi == 0) || multi),
            .bus_done  (bus_done),
            .bus_addr  (bus_cycle.addr),
            .hit_start (hs[gi]),
            .hit_end   (he[gi])
         );
      end
   endgenerate

   assign start_hit = |hs;
   assign end_hit   = |he;

   // ==========================================================================
   // Storage sequencing
   always_comb begin
      next_state = state;
      do_store   = 1'b0;
      seg_clr    = 1'b0;
      if (run_req) begin
         seg_clr = 1'b1;
         if ((mode == rtc_pkg::MODE_BEG_EV) && !auto_start) begin
            next_state = rtc_pkg::ST_ARMED;
         end else begin
            next_state = rtc_pkg::ST_STORE;
         end
      end else if (stop_req && (state != rtc_pkg::ST_IDLE)) begin
         next_state = rtc_pkg::ST_DONE;
      end else if (bus_done) begin
         unique case (state)
            rtc_pkg::ST_IDLE: begin
               next_state = state;
            end
            rtc_pkg::ST_ARMED: begin
               if (start_hit) begin
                  next_state = rtc_pkg::ST_STORE;
                  seg_clr    = 1'b1;
               end
            end
            rtc_pkg::ST_STORE: begin
               do_store = 1'b1;
               if ((mode == rtc_pkg::MODE_BEG_MON) || (mode == rtc_pkg::MODE_BEG_EV)) begin
                  if (seg_cnt + 12'h001 >= eff_len) begin
                     if ((mode == rtc_pkg::MODE_BEG_EV) && !freeze) begin
                        next_state = rtc_pkg::ST_ARMED;
                     end else begin
                        next_state = rtc_pkg::ST_DONE;
                     end
                  end
               end else if ((mode == rtc_pkg::MODE_END_EV) && end_hit) begin
                  next_state = rtc_pkg::ST_DONE;
               end else if ((mode == rtc_pkg::MODE_CTR_EV) && (start_hit || end_hit)) begin
                  next_state = rtc_pkg::ST_POST;
                  seg_clr    = 1'b1;
               end
            end
            rtc_pkg::ST_POST: begin
               do_store = 1'b1;
               if (seg_cnt + 12'h001 >= eff_len) begin
                  next_state = rtc_pkg::ST_DONE;
               end
            end
            rtc_pkg::ST_DONE: begin
               if (!freeze && start_hit &&
                   ((mode == rtc_pkg::MODE_END_EV) || (mode == rtc_pkg::MODE_CTR_EV))) begin
                  next_state = rtc_pkg::ST_STORE;
                  do_store   = 1'b1;
               end else if (!freeze && start_hit && (mode == rtc_pkg::MODE_BEG_EV)) begin
                  next_state = rtc_pkg::ST_STORE;
                  seg_clr    = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= rtc_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Segment counter for length-limited storage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seg_cnt <= 12'h000;
      end else if (seg_clr) begin
         seg_cnt <= 12'h000;
      end else if (do_store && (seg_cnt != rtc_pkg::CAP)) begin
         seg_cnt <= seg_cnt + 12'h001;
      end
   end

   // Write pointer wraps so new entries replace the oldest
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wptr <= 12'h000;
      end else if (run_req) begin
         wptr <= 12'h000;
      end else if (do_store) begin
         if (wptr == rtc_pkg::LAST_IDX) begin
            wptr <= 12'h000;
         end else begin
            wptr <= wptr + 12'h001;
         end
      end
   end

   // Stored cycle count saturates at capacity
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= 12'h000;
      end else if (run_req) begin
         count <= 12'h000;
      end else if (do_store && (count != rtc_pkg::CAP)) begin
         count <= count + 12'h001;
      end
   end

   assign trace_full    = (count == rtc_pkg::CAP);
   assign trace_storing = (state == rtc_pkg::ST_STORE) || (state == rtc_pkg::ST_POST);

   // ==========================================================================
   // Trace memory; readout uses its own port
   assign rd_sum = {1'b0, wptr} + {1'b0, rtc_pkg::CAP} - {1'b0, rd_cur};
   always_comb begin
      if (wptr >= rd_cur) begin
         rd_idx = wptr - rd_cur;
      end else begin
         rd_idx = rd_sum[11:0];
      end
   end

   rtc_mem u_mem (
      .clk   (clk),
      .we    (do_store),
      .waddr (wptr),
      .wdata (bus_cycle),
      .raddr (rd_idx),
      .rdata (rd_entry)
   );

   // ==========================================================================
   // APB slave, zero wait states
   assign setup   = psel && !penable;
   assign acc_wr  = psel && penable && pwrite;
   assign acc_rd  = psel && penable && !pwrite;
   assign ev_sel  = (paddr[7:4] == rtc_pkg::OFS_EV_BASE[7:4]) && (paddr[1:0] == 2'h0);
   assign ev_num  = paddr[3:2];
   assign pready  = 1'b1;

   always_comb begin
      unique case (paddr)
         rtc_pkg::OFS_CTRL, rtc_pkg::OFS_LENGTH, rtc_pkg::OFS_STATUS,
         rtc_pkg::OFS_RD_FROM, rtc_pkg::OFS_RD_TO, rtc_pkg::OFS_RD_DATA: mapped = 1'b1;
         default: mapped = ev_sel;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !mapped;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

   // Configuration writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_code  <= rtc_pkg::RST_MODE;
         auto_start <= rtc_pkg::RST_AUTO;
         multi      <= rtc_pkg::RST_MULTI;
         freeze     <= rtc_pkg::RST_FRZ;
         len_val    <= rtc_pkg::RST_LEN;
         len_max    <= rtc_pkg::RST_LENMAX;
      end else if (acc_wr && (paddr == rtc_pkg::OFS_CTRL)) begin
         mode_code  <= pwdata[rtc_pkg::CTRL_MODE_LSB +: 3];
         auto_start <= pwdata[rtc_pkg::CTRL_AUTO_BIT];
         multi      <= pwdata[rtc_pkg::CTRL_MULTI_BIT];
         freeze     <= pwdata[rtc_pkg::CTRL_FRZ_BIT];
      end else if (acc_wr && (paddr == rtc_pkg::OFS_LENGTH)) begin
         len_val    <= pwdata[12:0];
         len_max    <= pwdata[rtc_pkg::LEN_MAX_BIT];
      end
   end

   // Event point writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < rtc_pkg::NUM_EV; i++) begin
            ev_cfg[i] <= '0;
         end
      end else if (acc_wr && ev_sel) begin
         ev_cfg[ev_num] <= pwdata[rtc_pkg::EV_ROLE_BIT:0];
      end
   end

   // Readout cursor walks from the start index down to the end index
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_from <= rtc_pkg::RST_RD_IDX;
         rd_to   <= rtc_pkg::RST_RD_IDX;
         rd_cur  <= rtc_pkg::RST_RD_IDX;
         rd_end  <= 1'b0;
      end else if (acc_wr && (paddr == rtc_pkg::OFS_RD_FROM)) begin
         rd_from <= pwdata[11:0];
         rd_cur  <= pwdata[11:0];
         rd_end  <= 1'b0;
      end else if (acc_wr && (paddr == rtc_pkg::OFS_RD_TO)) begin
         rd_to   <= pwdata[11:0];
         rd_cur  <= rd_from;
         rd_end  <= 1'b0;
      end else if (acc_rd && (paddr == rtc_pkg::OFS_RD_DATA) && !rd_end) begin
         if (rd_cur > rd_to) begin
            rd_cur <= rd_cur - 12'h001;
         end else begin
            rd_end <= 1'b1;
         end
      end
   end

   // Read data is latched in the setup cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            rtc_pkg::OFS_CTRL: begin
               prdata[rtc_pkg::CTRL_MODE_LSB +: 3] <= mode_code;
               prdata[rtc_pkg::CTRL_AUTO_BIT]      <= auto_start;
               prdata[rtc_pkg::CTRL_MULTI_BIT]     <= multi;
               prdata[rtc_pkg::CTRL_FRZ_BIT]       <= freeze;
            end
            rtc_pkg::OFS_LENGTH: begin
               prdata[12:0]                  <= len_val;
               prdata[rtc_pkg::LEN_MAX_BIT] <= len_max;
            end
            rtc_pkg::OFS_STATUS: begin
               prdata[11:0]                  <= count;
               prdata[rtc_pkg::ST_FULL_BIT]  <= trace_full;
               prdata[rtc_pkg::ST_STORE_BIT] <= trace_storing;
               prdata[rtc_pkg::ST_ARMED_BIT] <= (state == rtc_pkg::ST_ARMED);
               prdata[rtc_pkg::ST_RDEND_BIT] <= rd_end;
            end
            rtc_pkg::OFS_RD_FROM: prdata[11:0] <= rd_from;
            rtc_pkg::OFS_RD_TO:   prdata[11:0] <= rd_to;
            rtc_pkg::OFS_RD_DATA: prdata       <= rd_entry;
            default: begin
               if (ev_sel) begin
                  prdata[rtc_pkg::EV_ROLE_BIT:0] <= ev_cfg[ev_num];
               end
            end
         endcase
      end
   end

endmodule

// ==== verif/rtc_far.sv ====
// Model of the emulated processor bus and run control
`timescale 1ns/1ps
module rtc_far (
   input wire logic           clk,       // Clock
   output logic               bus_done,  // Cycle done
   output rtc_pkg::rtc_entry_t bus_cycle, // Cycle
   output logic               run_req,   // Run pulse
   output logic               stop_req   // Stop pulse
);
   initial begin
      bus_done  = 1'b0;
      bus_cycle = 32'h00000000;
      run_req   = 1'b0;
      stop_req  = 1'b0;
   end
   // One completed cycle, then an idle gap; released bus shows the inverse
   task send(input rtc_pkg::rtc_entry_t e, input int gap);
      @(posedge clk);
      bus_done  <= 1'b1;
      bus_cycle <= e;
      @(posedge clk);
      bus_done  <= 1'b0;
      bus_cycle <= ~e;
      repeat (gap) @(posedge clk);
   endtask
   task pulse(input logic stop);
      @(posedge clk);
      if (stop) stop_req <= 1'b1;
      else run_req <= 1'b1;
      @(posedge clk);
      run_req  <= 1'b0;
      stop_req <= 1'b0;
   endtask
endmodule

// ==== verif/rtc_sva.sv ====
// Port checker for the trace capture block
`timescale 1ns/1ps
module rtc_sva (
   input wire logic                clk,           // Clock
   input wire logic                rstn,          // Reset
   input wire logic                psel,          // APB
   input wire logic                penable,       // APB
   input wire logic                pwrite,        // APB
   input wire logic [7:0]          paddr,         // APB
   input wire logic [31:0]         pwdata,        // APB
   input wire logic [31:0]         prdata,        // APB
   input wire logic                pready,        // APB
   input wire logic                pslverr,       // APB
   input wire logic                bus_done,      // Cycle done
   input wire rtc_pkg::rtc_entry_t bus_cycle,     // Cycle
   input wire logic                run_req,       // Run
   input wire logic                stop_req,      // Stop
   input wire logic                trace_storing, // Storing
   input wire logic                trace_full     // Full
);
   logic [2:0] mode;
   logic       aut;
   logic       mapped;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================================================
   // Shadow of the mode field
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode <= 3'h1;
         aut  <= 1'b0;
      end else if (psel && penable && pwrite && paddr == rtc_pkg::OFS_CTRL) begin
         mode <= pwdata[2:0];
         aut  <= pwdata[3];
      end
   end
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                                 8'h20, 8'h24, 8'h28, 8'h2c};
   // ==========================================================================
   // Properties
   property p_run_store;
      run_req && mode != rtc_pkg::CODE_BEG_EV |=> trace_storing;
   endproperty
   a_run_store: assert property (p_run_store) else $error("no storage after run");
   property p_run_arm;
      run_req && mode == rtc_pkg::CODE_BEG_EV && !aut |=> !trace_storing;
   endproperty
   a_run_arm: assert property (p_run_arm) else $error("stored before event");
   property p_run_auto;
      run_req && mode == rtc_pkg::CODE_BEG_EV && aut |=> trace_storing;
   endproperty
   a_run_auto: assert property (p_run_auto) else $error("auto start ignored");
   property p_stop;
      stop_req && !run_req |=> !trace_storing;
   endproperty
   a_stop: assert property (p_stop) else $error("storing after stop");
   property p_full_cause;
      $rose(trace_full) |-> $past(bus_done);
   endproperty
   a_full_cause: assert property (p_full_cause) else $error("full without cycle");
   property p_full_hold;
      trace_full && !run_req |=> trace_full;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full dropped");
   property p_clr;
      run_req |=> !trace_full;
   endproperty
   a_clr: assert property (p_clr) else $error("count not cleared");
   property p_err;
      psel && penable && !mapped |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("unmapped access accepted");
   property p_idle;
      !trace_storing && !run_req && !bus_done |=> !trace_storing;
   endproperty
   a_idle: assert property (p_idle) else $error("storage without trigger");
   c_center: cover property (run_req && mode == rtc_pkg::CODE_CTR_EV);
   c_full: cover property ($rose(trace_full));
   c_err: cover property (pslverr);
endmodule
bind rtc_top rtc_sva u_sva (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .bus_done(bus_done), .bus_cycle(bus_cycle), .run_req(run_req),
   .stop_req(stop_req), .trace_storing(trace_storing), .trace_full(trace_full));

// ==== verif/rtc_top_tb.sv ====
// Self-checking bench for the trace capture block
`timescale 1ns/1ps
module rtc_top_tb;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, bus_done, run_req, stop_req;
   logic trace_storing, trace_full;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed, r, q[$];
   logic        e;
   rtc_pkg::rtc_entry_t bus_cycle;
   int fail_count, checks_done, cyc, tn;
   rtc_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_done(bus_done), .bus_cycle(bus_cycle), .run_req(run_req), .stop_req(stop_req),
      .trace_storing(trace_storing), .trace_full(trace_full));
   rtc_far u_far (.clk(clk), .bus_done(bus_done), .bus_cycle(bus_cycle),
      .run_req(run_req), .stop_req(stop_req));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ==========================================================================
   // One storage run against the queue model
   task run_case(input int m, input int au, input int ln, input int n, input int hp);
      rtc_pkg::rtc_entry_t x;
      int st, left, sz, k, tot;
      // Bit 1 of au selects multi-trigger, event point 1 and freeze off
      apb(1'b1, rtc_pkg::OFS_CTRL, 32'(m) | 32'(au << 3) | ((au & 2) ? 32'h0 : 32'h20));
      apb(1'b1, rtc_pkg::OFS_LENGTH, 32'(ln));
      apb(1'b1, rtc_pkg::OFS_EV_BASE + 8'((au & 2) * 2),
          {14'h0, (m > 2), (m != 1), 16'h8abc});
      u_far.pulse(1'b0);
      q.delete();
      tot = 0;
      left = ln;
      st = (m == 2 && au == 0) ? 1 : 2;
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         x = seed;
         x.addr[15] = 1'b0;
         if (i == hp) x.addr = 16'h8abc;
         u_far.send(x, (i % 3 == 0) ? 2 : 0);
         if (st == 1 && i == hp) st = 2;
         else if (st == 2 || st == 3) begin
            q.push_back(x);
            tot++;
            if (q.size() > 4095) void'(q.pop_front());
            if (m == 3 && i == hp) st = 4;
            else if (m == 4 && i == hp && st == 2) st = 3;
            else if (m == 0 || m == 2 || st == 3) begin
               left--;
               if (left == 0) st = 4;
            end
         end
      end
      sz = q.size();
      k = (sz < 6) ? sz : 6;
      apb(1'b1, rtc_pkg::OFS_RD_FROM, 32'(k));
      apb(1'b1, rtc_pkg::OFS_RD_TO, 32'h1);
      for (int j = k; j > 0; j--) begin
         apb(1'b0, rtc_pkg::OFS_RD_DATA, 32'h0);
         chk(r, q[sz - j]);
      end
      if (sz == 4095) begin
         apb(1'b1, rtc_pkg::OFS_RD_FROM, 32'd4095);
         apb(1'b1, rtc_pkg::OFS_RD_TO, 32'd4095);
         apb(1'b0, rtc_pkg::OFS_RD_DATA, 32'h0);
         chk(r, q[0]);
      end
      u_far.pulse(1'b1);
      apb(1'b0, rtc_pkg::OFS_STATUS, 32'h0);
      chk(r & 32'h70fff, ((tot > 4095) ? 32'd4095 : 32'(tot)) |
          ((tot >= 4095) ? 32'h10000 : 32'h0));
      tn++;
      $display("test %0d done", tn);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ==========================================================================
   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {fail_count, checks_done, cyc, tn} = '0;
      seed = 32'h00012b35;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, rtc_pkg::OFS_CTRL, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, rtc_pkg::OFS_LENGTH, 32'h0);
      chk(r, 32'h00010000);
      apb(1'b1, rtc_pkg::OFS_STATUS, 32'hffffffff);
      apb(1'b0, rtc_pkg::OFS_STATUS, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk({r[30:0], e}, 32'h1);
      $display("test reset values done");
      run_case(0, 0, 3, 6, -1);
      run_case(2, 0, 3, 8, 2);
      run_case(2, 1, 2, 6, 4);
      run_case(3, 0, 5, 8, 4);
      run_case(4, 0, 2, 9, 3);
      run_case(1, 0, 5, 4100, -1);
      run_case(3, 2, 5, 8, 4);
      end_of_test();
   end
endmodule
